/* src/pcgu_map.vh */
// register map, field positions, reset values and timing counts of the loop clock unit
`ifndef PCGU_MAP_VH
`define PCGU_MAP_VH

// ==========================================================
// register offsets
`define PCGU_SYNTH_ADDR      8'h00
`define PCGU_REFERENCE_DIVIDER_ADDR     8'h01
`define PCGU_POST_DIVIDER_ADDR    8'h02
`define PCGU_CLKSEL_ADDR     8'h03
`define PCGU_IRQCTL_ADDR     8'h04
`define PCGU_STATUS_ADDR     8'h05
`define PCGU_OSC_ADDR        8'h06
`define PCGU_TEST_ADDR       8'h07

// ==========================================================
// field positions
`define PCGU_SYN_MSB         5
`define PCGU_VCO_RANGE_LSB   6
`define PCGU_REFERENCE_DIVIDER_MSB      3
`define PCGU_REF_RANGE_LSB   6
`define PCGU_POST_MSB        4
`define PCGU_SELECT_BIT      7
`define PCGU_LOCK_CHANGE_IRQ_ENABLE_BIT      4
`define PCGU_OSC_STATUS_IRQ_ENABLE_BIT       3
`define PCGU_LOCK_BIT        3
`define PCGU_EXTERNAL_OSC_ENABLE_BIT        7
`define PCGU_CORE_LOW_BIT    5
`define PCGU_FLASH_LOW_BIT   4
`define PCGU_IO_LOW_BIT      3
`define PCGU_CLKOUT_BIT      0

// ==========================================================
// reset values
`define PCGU_SYN_RST         6'h1F
`define PCGU_VCO_RANGE_RST   2'h1
`define PCGU_REF_RANGE_RST   2'h0
`define PCGU_REFERENCE_DIVIDER_RST      4'h0
`define PCGU_POST_RST        5'h03
`define PCGU_UNLOCK_VALUE    8'hE3

// ==========================================================
// timing
`define PCGU_CLK_PERIOD_NS   25
`define PCGU_IRC_PERIOD_NS   1000
`define PCGU_TIME_SCALE      4
// scaled internal reference period over the clock period, minus one (4000 / 25 - 1)
`define PCGU_IRC_DIV         8'h9F
`define PCGU_UNLOCKED_DIV    8'h03
`define PCGU_BUS_DIV         8'h01
`define PCGU_NCO_RST         16'h6666
`define PCGU_NCO_STEP        16'h0020
`define PCGU_FB_PER_REF      2'h2
`define PCGU_LOCK_WINDOWS    3'h4
`define PCGU_UNLOCK_WINDOWS  3'h2

`endif

/* src/pcgu_clkdiv.v */
// tick divider: passes one of every div+1 input ticks
`timescale 1ns/1ps
module pcgu_clkdiv (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       restart,
  input  wire       tick_in,
  input  wire [7:0] div,
  output reg        tick_out
);

  reg [7:0] cnt;

  // ==========================================================
  // count input ticks
  always @(posedge ref_clk) begin
    if (!rst_n || restart) begin
      cnt      <= 8'h00;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (cnt >= div) begin
          cnt      <= 8'h00;
          tick_out <= 1'b1;
        end else begin
          cnt <= cnt + 8'h01;
        end
      end
    end
  end

endmodule // pcgu_clkdiv

/* src/pcgu_lockdet.v */
// phase detector and lock detector of the loop
`include "pcgu_map.vh"
`timescale 1ns/1ps
module pcgu_lockdet (
  input  wire ref_clk,
  input  wire rst_n,
  input  wire restart,
  input  wire ref_tick,
  input  wire fb_tick,
  output reg  pd_up,
  output reg  pd_dn,
  output reg  locked
);

  reg [1:0] fb_cnt;
  reg [2:0] good_cnt;
  reg [2:0] bad_cnt;
  wire [1:0] fb_total;

  assign fb_total = (fb_cnt == 2'h3) ? 2'h3 : fb_cnt + {1'b0, fb_tick};

  // ==========================================================
  // window per reference period
  always @(posedge ref_clk) begin
    if (!rst_n || restart) begin
      fb_cnt   <= 2'h0;
      good_cnt <= 3'h0;
      bad_cnt  <= 3'h0;
      pd_up    <= 1'b0;
      pd_dn    <= 1'b0;
      locked   <= 1'b0;
    end else begin
      pd_up <= 1'b0;
      pd_dn <= 1'b0;
      if (ref_tick) begin
        fb_cnt <= 2'h0;
        pd_up <= (fb_total < `PCGU_FB_PER_REF);
        pd_dn <= (fb_total > `PCGU_FB_PER_REF);
        if (fb_total == `PCGU_FB_PER_REF) begin
          bad_cnt <= 3'h0;
          if (good_cnt != `PCGU_LOCK_WINDOWS)
            good_cnt <= good_cnt + 3'h1;
          if (good_cnt + 3'h1 >= `PCGU_LOCK_WINDOWS)
            locked <= 1'b1;
        end else begin
          good_cnt <= 3'h0;
          if (bad_cnt != `PCGU_UNLOCK_WINDOWS)
            bad_cnt <= bad_cnt + 3'h1;
          if (bad_cnt + 3'h1 >= `PCGU_UNLOCK_WINDOWS)
            locked <= 1'b0;
        end
      end else begin
        fb_cnt <= fb_total;
      end
    end
  end

endmodule // pcgu_lockdet

/* src/pcgu_top.v */
// loop clock generation unit: reference, vco model, dividers, lock and test register
`include "pcgu_map.vh"
`timescale 1ns/1ps
module pcgu_top (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire [7:0] addr,
  input  wire [7:0] wr_data,
  input  wire       wr_en,
  input  wire       rd_en,
  output reg  [7:0] rd_data,
  input  wire       external_osc_clock,
  input  wire       special_mode,
  input  wire       full_performance_mode,
  input  wire       core_supply_low,
  input  wire       flash_supply_low,
  input  wire       io_supply_low,
  input  wire       periodic_clock,
  input  wire       periodic_feature_enable,
  input  wire       periodic_external_access,
  input  wire       full_stop_entry,
  output reg        periodic_clock_pin,
  output reg        vco_clock,
  output reg        pll_reference_clock,
  output wire       feedback_clock,
  output wire       loop_output_clock,
  output wire       bus_clock,
  output wire       lock_status,
  output reg        lock_change_irq,
  output reg        loop_clock_select
);

  // ==========================================================
  // control registers
  reg [5:0]  synth_multiplier;
  reg [1:0]  vco_range_select;
  reg [3:0]  reference_divider;
  reg [1:0]  reference_range_select;
  reg [4:0]  post_divider;
  reg        lock_change_irq_enable;
  reg        osc_status_irq_enable;
  reg        external_osc_enable;
  reg        periodic_clock_out_enable;
  reg        test_unlocked;
  reg        lock_prev;
  reg [15:0] nco_acc;
  reg [15:0] nco_ctl;
  reg [7:0]  next_rd_data;

  wire       internal_one_meg_osc;
  wire       osc_div_tick;
  wire       ref_tick_src;
  wire       pd_up;
  wire       pd_dn;
  wire       loop_restart;
  wire [7:0] post_div_sel;
  wire       bus_src_tick;
  wire [16:0] nco_sum;
  wire       wr_synth;
  wire       wr_reference_divider;
  wire       wr_osc;
  wire       wr_test;
  wire       core_supply_low_status;
  wire       flash_supply_low_status;
  wire       io_supply_low_status;

  // ==========================================================
  // address decode
  function hit;
    input [7:0] a;
    input [7:0] target;
    begin
      hit = (a == target);
    end
  endfunction

  assign wr_synth  = wr_en && hit(addr, `PCGU_SYNTH_ADDR);
  assign wr_reference_divider = wr_en && hit(addr, `PCGU_REFERENCE_DIVIDER_ADDR);
  assign wr_osc    = wr_en && hit(addr, `PCGU_OSC_ADDR);
  assign wr_test   = wr_en && hit(addr, `PCGU_TEST_ADDR);

  // a change of loop setting restarts lock acquisition
  assign loop_restart = wr_synth || wr_reference_divider || wr_osc;

  // ==========================================================
  // register writes
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      synth_multiplier       <= `PCGU_SYN_RST;
      vco_range_select       <= `PCGU_VCO_RANGE_RST;
      reference_divider      <= `PCGU_REFERENCE_DIVIDER_RST;
      reference_range_select <= `PCGU_REF_RANGE_RST;
      post_divider           <= `PCGU_POST_RST;
      loop_clock_select      <= 1'b1;
      lock_change_irq_enable <= 1'b0;
      osc_status_irq_enable  <= 1'b0;
      external_osc_enable    <= 1'b0;
    end else begin
      if (wr_synth) begin
        synth_multiplier <= wr_data[`PCGU_SYN_MSB:0];
        vco_range_select <= wr_data[`PCGU_VCO_RANGE_LSB+1:`PCGU_VCO_RANGE_LSB];
      end
      if (wr_reference_divider) begin
        reference_divider      <= wr_data[`PCGU_REFERENCE_DIVIDER_MSB:0];
        reference_range_select <= wr_data[`PCGU_REF_RANGE_LSB+1:`PCGU_REF_RANGE_LSB];
      end
      if (wr_en && hit(addr, `PCGU_POST_DIVIDER_ADDR))
        post_divider <= wr_data[`PCGU_POST_MSB:0];
      if (full_stop_entry)
        loop_clock_select <= 1'b1;
      else if (wr_en && hit(addr, `PCGU_CLKSEL_ADDR))
        loop_clock_select <= wr_data[`PCGU_SELECT_BIT];
      if (wr_en && hit(addr, `PCGU_IRQCTL_ADDR)) begin
        lock_change_irq_enable <= wr_data[`PCGU_LOCK_CHANGE_IRQ_ENABLE_BIT];
        osc_status_irq_enable  <= wr_data[`PCGU_OSC_STATUS_IRQ_ENABLE_BIT];
      end
      if (wr_osc)
        external_osc_enable <= wr_data[`PCGU_EXTERNAL_OSC_ENABLE_BIT];
    end
  end

  // ==========================================================
  // factory test register
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      test_unlocked             <= 1'b0;
      periodic_clock_out_enable <= 1'b0;
    end else if (!special_mode) begin
      test_unlocked <= 1'b0;
    end else if (wr_test) begin
      if (!test_unlocked) begin
        test_unlocked <= (wr_data == `PCGU_UNLOCK_VALUE);
      end else begin
        periodic_clock_out_enable <= wr_data[`PCGU_CLKOUT_BIT];
      end
    end
  end

  assign core_supply_low_status  = core_supply_low && full_performance_mode;
  assign flash_supply_low_status = flash_supply_low && full_performance_mode;
  assign io_supply_low_status    = io_supply_low && full_performance_mode;

  // ==========================================================
  // periodic clock output
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      periodic_clock_pin <= 1'b0;
    end else begin
      periodic_clock_pin <= periodic_clock_out_enable && periodic_feature_enable &&
                            !periodic_external_access && periodic_clock;
    end
  end

  // ==========================================================
  // reference clock
  // internal one megahertz tick
  pcgu_clkdiv u_irc_div (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .restart  (1'b0),
    .tick_in  (1'b1),
    .div      (`PCGU_IRC_DIV),
    .tick_out (internal_one_meg_osc)
  );

  pcgu_clkdiv u_ref_div (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .restart  (loop_restart),
    .tick_in  (external_osc_clock),
    .div      ({4'h0, reference_divider}),
    .tick_out (osc_div_tick)
  );

  assign ref_tick_src        = external_osc_enable ? osc_div_tick : internal_one_meg_osc;

  // ==========================================================
  // reference tick output
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pll_reference_clock <= 1'b0;
    end else begin
      pll_reference_clock <= ref_tick_src;
    end
  end

  // ==========================================================
  // vco model: accumulator steered by correction pulses
  assign nco_sum = {1'b0, nco_acc} + {1'b0, nco_ctl};

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      nco_acc   <= 16'h0000;
      nco_ctl   <= `PCGU_NCO_RST;
      vco_clock <= 1'b0;
    end else begin
      nco_acc   <= nco_sum[15:0];
      vco_clock <= nco_sum[16];
      if (pd_up && (nco_ctl <= 16'hFFFF - `PCGU_NCO_STEP))
        nco_ctl <= nco_ctl + `PCGU_NCO_STEP;
      else if (pd_dn && (nco_ctl > `PCGU_NCO_STEP))
        nco_ctl <= nco_ctl - `PCGU_NCO_STEP;
    end
  end

  // ==========================================================
  // feedback clock
  // multiplier via feedback divider
  pcgu_clkdiv u_fb_div (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .restart  (loop_restart),
    .tick_in  (vco_clock),
    .div      ({2'h0, synth_multiplier}),
    .tick_out (feedback_clock)
  );

  // ==========================================================
  // phase and lock detector
  // lock decision
  pcgu_lockdet u_lockdet (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .restart  (loop_restart),
    .ref_tick (ref_tick_src),
    .fb_tick  (feedback_clock),
    .pd_up    (pd_up),
    .pd_dn    (pd_dn),
    .locked   (lock_status)
  );

  // ==========================================================
  // loop output clock
  // post divider when locked
  assign post_div_sel = lock_status ? {3'h0, post_divider} : `PCGU_UNLOCKED_DIV;

  pcgu_clkdiv u_post_div (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .restart  (1'b0),
    .tick_in  (vco_clock),
    .div      (post_div_sel),
    .tick_out (loop_output_clock)
  );

  // ==========================================================
  // bus clock
  // half of selected source
  assign bus_src_tick = loop_clock_select ? loop_output_clock : external_osc_clock;

  pcgu_clkdiv u_bus_div (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .restart  (1'b0),
    .tick_in  (bus_src_tick),
    .div      (`PCGU_BUS_DIV),
    .tick_out (bus_clock)
  );

  // ==========================================================
  // lock change request
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      lock_prev       <= 1'b0;
      lock_change_irq <= 1'b0;
    end else begin
      lock_prev <= lock_status;
      lock_change_irq <= lock_change_irq_enable && (lock_prev != lock_status);
    end
  end

  // ==========================================================
  // read data
  always @* begin
    next_rd_data = 8'h00;
    case (addr)
      `PCGU_SYNTH_ADDR:   next_rd_data = {vco_range_select, synth_multiplier};
      `PCGU_REFERENCE_DIVIDER_ADDR:  next_rd_data = {reference_range_select, 2'h0, reference_divider};
      `PCGU_POST_DIVIDER_ADDR: next_rd_data = {3'h0, post_divider};
      `PCGU_CLKSEL_ADDR:  next_rd_data[`PCGU_SELECT_BIT] = loop_clock_select;
      `PCGU_IRQCTL_ADDR: begin
        next_rd_data[`PCGU_LOCK_CHANGE_IRQ_ENABLE_BIT] = lock_change_irq_enable;
        next_rd_data[`PCGU_OSC_STATUS_IRQ_ENABLE_BIT]  = osc_status_irq_enable;
      end
      `PCGU_STATUS_ADDR:  next_rd_data[`PCGU_LOCK_BIT] = lock_status;
      `PCGU_OSC_ADDR:     next_rd_data[`PCGU_EXTERNAL_OSC_ENABLE_BIT] = external_osc_enable;
      `PCGU_TEST_ADDR: begin
        next_rd_data[`PCGU_CORE_LOW_BIT]  = core_supply_low_status;
        next_rd_data[`PCGU_FLASH_LOW_BIT] = flash_supply_low_status;
        next_rd_data[`PCGU_IO_LOW_BIT]    = io_supply_low_status;
        next_rd_data[`PCGU_CLKOUT_BIT]    = periodic_clock_out_enable;
      end
      default:            next_rd_data = 8'h00;
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rst_n)
      rd_data <= 8'h00;
    else if (rd_en)
      rd_data <= next_rd_data;
    else
      rd_data <= 8'h00;
  end

endmodule // pcgu_top

/* test/pcgu_top_checker.sv */
// port assertions of the loop clock unit
`timescale 1ns/1ps
module pcgu_top_checker (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic [7:0] addr,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rd_data,
  input wire logic       periodic_clock,
  input wire logic       periodic_feature_enable,
  input wire logic       periodic_external_access,
  input wire logic       full_stop_entry,
  input wire logic       periodic_clock_pin,
  input wire logic       bus_clock,
  input wire logic       lock_status,
  input wire logic       lock_change_irq,
  input wire logic       loop_clock_select
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // sequences
  sequence s_rd(a);
    rd_en && addr == a;
  endsequence
  sequence s_cfg_wr;
    wr_en && (addr == 8'h00 || addr == 8'h01 || addr == 8'h06);
  endsequence
  // ==========================================
  // assertions
  chk_rd_idle_zero:
    assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data not zero outside read cycle");
  chk_status_read:
    assert property (s_rd(8'h05) |=> rd_data == {4'h0, $past(lock_status), 3'h0})
    else $error("status read wrong");
  chk_unmapped_read:
    assert property (rd_en && addr > 8'h07 |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  chk_pin_gated:
    assert property (!($past(periodic_feature_enable) && !$past(periodic_external_access)
                       && $past(periodic_clock)) |-> !periodic_clock_pin)
    else $error("clock pin driven while gated");
  chk_irq_toggle:
    assert property (lock_change_irq |-> $past(lock_status) != $past(lock_status, 2))
    else $error("irq without lock toggle");
  chk_irq_single:
    assert property (lock_change_irq |=> !lock_change_irq)
    else $error("irq longer than one cycle");
  chk_restart_unlock:
    assert property (s_cfg_wr |-> ##2 !lock_status)
    else $error("lock held after config write");
  chk_stop_select:
    assert property (full_stop_entry |=> loop_clock_select)
    else $error("select not set on full stop");
  chk_bus_half:
    assert property (bus_clock |=> !bus_clock)
    else $error("bus tick faster than half rate");
endmodule // pcgu_top_checker

bind pcgu_top pcgu_top_checker i_pcgu_top_checker (.ref_clk, .rst_n, .addr, .wr_en,
  .rd_en, .rd_data, .periodic_clock, .periodic_feature_enable, .periodic_external_access,
  .full_stop_entry, .periodic_clock_pin, .bus_clock, .lock_status, .lock_change_irq,
  .loop_clock_select);

/* test/pcgu_top_tb.sv */
// self-checking bench of the loop clock unit
`timescale 1ns/1ps
module pcgu_top_tb;
  logic       ref_clk, rst_n, wr_en, rd_en, external_osc_clock, special_mode;
  logic       full_performance_mode, core_supply_low, flash_supply_low, io_supply_low;
  logic       periodic_clock, periodic_feature_enable, periodic_external_access;
  logic       full_stop_entry;
  logic [7:0] addr, wr_data;
  wire  [7:0] rd_data;
  wire        periodic_clock_pin, vco_clock, pll_reference_clock, feedback_clock;
  wire        loop_output_clock, bus_clock, lock_status, lock_change_irq, loop_clock_select;
  int         fails, num_checks, oc, nv, nl, nf, nb, nr, no;

  pcgu_top i_pcgu_top (.ref_clk, .rst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .external_osc_clock, .special_mode, .full_performance_mode, .core_supply_low,
    .flash_supply_low, .io_supply_low, .periodic_clock, .periodic_feature_enable,
    .periodic_external_access, .full_stop_entry, .periodic_clock_pin, .vco_clock,
    .pll_reference_clock, .feedback_clock, .loop_output_clock, .bus_clock,
    .lock_status, .lock_change_irq, .loop_clock_select);

  // ==========================================
  // clock and oscillator ticks
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      oc                 <= 0;
      external_osc_clock <= 1'b0;
    end else begin
      oc                 <= (oc == 9) ? 0 : oc + 1;
      external_osc_clock <= (oc == 0);
    end
  end

  // ==========================================
  // helpers
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [7:0] exp, got, input string nm);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task near(input int got, exp, tol, input string nm);
    num_checks++;
    if (got > exp + tol || exp > got + tol) begin
      fails++;
      $display("Error %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    addr <= a; wr_data <= d; wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [7:0] a, exp, input string nm);
    @(posedge ref_clk);
    addr <= a; rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(posedge ref_clk);
    chk(exp, rd_data, nm);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task measure(input int n);
    nv = 0; nl = 0; nf = 0; nb = 0; nr = 0; no = 0;
    repeat (n) begin
      @(posedge ref_clk);
      nv += vco_clock; nl += loop_output_clock; nf += feedback_clock;
      nb += bus_clock; nr += pll_reference_clock; no += external_osc_clock;
    end
  endtask

  // ==========================================
  // scenarios
  task t_reset_values;
    logic [7:0] tab [8] = '{8'h5F, 8'h00, 8'h03, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) rd(i[7:0], tab[i], "reset value");
    rd(8'h08, 8'h00, "unmapped");
  endtask
  task t_regs;
    wr(8'h02, 8'h1F);
    rd(8'h02, 8'h1F, "post divider");
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'h00, "status");
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'h00, "unmapped");
    wr(8'h02, 8'h03);
  endtask
  task t_test_reg;
    wr(8'h07, 8'hE3); wr(8'h07, 8'h01);
    rd(8'h07, 8'h00, "test normal mode");
    special_mode <= 1'b1;
    wr(8'h07, 8'h01);
    rd(8'h07, 8'h00, "test locked");
    wr(8'h07, 8'hE3); wr(8'h07, 8'h01);
    rd(8'h07, 8'h01, "test unlocked");
    full_performance_mode <= 1'b1; core_supply_low <= 1'b1; flash_supply_low <= 1'b1;
    io_supply_low <= 1'b1;
    rd(8'h07, 8'h39, "supply low fpm");
    full_performance_mode <= 1'b0;
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'h01, "supply low rpm");
    periodic_feature_enable <= 1'b1; periodic_clock <= 1'b1;
    cyc(3); chk(1'b1, periodic_clock_pin, "pin routed");
    periodic_external_access <= 1'b1;
    cyc(3); chk(1'b0, periodic_clock_pin, "pin ext access");
    periodic_external_access <= 1'b0;
    wr(8'h07, 8'h00);
    cyc(3); chk(1'b0, periodic_clock_pin, "pin disabled");
  endtask
  task t_lock;
    wr(8'h04, 8'h10);
    for (int i = 0; i < 4000 && lock_status !== 1'b1; i++) cyc(1);
    chk(1'b1, lock_status, "lock");
    cyc(1); chk(1'b1, lock_change_irq, "lock irq");
    rd(8'h05, 8'h08, "status locked");
    measure(1280);
    near(nr, 8, 1, "internal ref ticks");
    near(nf, 2 * nr, 2, "feedback per ref");
    near(nv, 32 * nf, 32, "vco per feedback");
    near(nv, 4 * nl, 4, "post divide four");
    near(nl, 2 * nb, 2, "bus half");
    wr(8'h02, 8'h01);
    measure(640);
    near(nv, 2 * nl, 2, "post divide two");
    wr(8'h00, 8'h5F);
    cyc(2); chk(1'b0, lock_status, "unlock");
    chk(1'b1, lock_change_irq, "unlock irq");
    measure(320);
    near(nv, 4 * nl, 4, "unlocked divide");
  endtask
  task t_osc;
    wr(8'h00, 8'h43);
    wr(8'h06, 8'h80);
    wr(8'h01, 8'h43);
    measure(800);
    near(no, 4 * nr, 4, "osc ref divide");
    wr(8'h03, 8'h00);
    measure(800);
    near(no, 2 * nb, 2, "bus from osc");
    wr(8'h04, 8'h00);
    @(posedge ref_clk) full_stop_entry <= 1'b1;
    @(posedge ref_clk) full_stop_entry <= 1'b0;
    rd(8'h03, 8'h80, "select after stop");
  endtask

  // ==========================================
  // main sequence and watchdog
  initial begin
    {rst_n, wr_en, rd_en, special_mode, full_performance_mode, full_stop_entry} = '0;
    {core_supply_low, flash_supply_low, io_supply_low, periodic_clock} = '0;
    {periodic_feature_enable, periodic_external_access} = '0;
    addr = 8'h00; wr_data = 8'h00; fails = 0; num_checks = 0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset_values;
    t_regs;
    t_test_reg;
    t_lock;
    t_osc;
    print_verdict;
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    print_verdict;
  end
endmodule // pcgu_top_tb
